// >>> logic/ext_mem_pkg.sv
// ext_mem_pkg: shared constants and types of the external memory strobe timer
// assumes an 8-bit special-function register port and one system clock
package ext_mem_pkg;
  // ----------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMING_ADDR = 8'h84;
  localparam logic [7:0] CONFIG_ADDR = 8'h85;
  localparam logic [7:0] BANK_ADDR   = 8'hAA;
  localparam logic [7:0] TIMING_RST  = 8'hFF;
  localparam logic [7:0] CONFIG_RST  = 8'h00;
  localparam logic [7:0] BANK_RST    = 8'h00;
  localparam logic [7:0] CONFIG_MASK = 8'h1F;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SETUP_LSB  = 6;
  localparam int SETUP_MSB  = 7;
  localparam int WIDTH_LSB  = 2;
  localparam int WIDTH_MSB  = 5;
  localparam int HOLD_LSB   = 0;
  localparam int HOLD_MSB   = 1;
  localparam int LATCH_LSB  = 0;
  localparam int LATCH_MSB  = 1;
  localparam int MUX_BIT    = 4;
  localparam int REGION_LSB = 2;
  localparam int REGION_MSB = 3;
  localparam logic [1:0] REGION_BANK = 2'h2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TMR_W          = 4;
  localparam int ACCESS_OVERHEAD = 4;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ALE_HI, ST_ALE_LO, ST_SETUP,
    ST_STROBE, ST_HOLD, ST_RELEASE, ST_DONE
  } state_t;
endpackage : ext_mem_pkg

// >>> logic/phase_timer_if.sv
// phase_timer_if: load and expiry signals between sequencer and phase timer
// assumes both ends run on the system clock
`timescale 1ns/10ps
interface phase_timer_if;
  import ext_mem_pkg::*;
  logic             load;
  logic [TMR_W-1:0] load_val;
  logic             zero;
  modport ctl (output load, output load_val, input zero);
  modport tmr (input load, input load_val, output zero);
endinterface : phase_timer_if

// >>> logic/phase_timer.sv
// phase_timer: down counter that measures one bus phase in system clocks
// assumes a synchronous active-high reset
`timescale 1ns/10ps
module phase_timer (
  input  wire logic   i_sys_clk,
  input  wire logic   i_reset,
  phase_timer_if.tmr  tif
);
  import ext_mem_pkg::*;
  logic [TMR_W-1:0] cnt_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt_ff <= '0;
    end else if (tif.load) begin
      cnt_ff <= tif.load_val;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign tif.zero = (cnt_ff == '0);
endmodule : phase_timer

// >>> logic/ext_mem_timing.sv
// ext_mem_timing: sequencer for off-chip data memory accesses
// assumes the core raises i_acc_req only for off-chip accesses, holds it one cycle
//
// Overview of operation
// - setup field inserts 0-3 cycles before strobe
// - strobe width is field plus one cycles
// - hold field keeps address 0-3 cycles after
// - timing register at 0x84, page independent
// - codes 101/110/111 give non-multiplexed wide accesses
// - codes 001/010/011 give multiplexed wide accesses
// - 101/111 narrow non-multiplexed: upper byte undriven
// - 001/011 narrow multiplexed: upper byte undriven
// - 110 narrow non-multiplexed: upper byte from bank
// - 010 narrow multiplexed: upper byte from bank
// - narrow access low byte is indirect pointer
// - latch strobe high lasts 1-4 cycles
// - latch strobe low lasts 1-4 cycles
// - write data leads strobe release 1-19 cycles
// - write data held 0-3 cycles after release
// - reset loads largest setup, width, hold
// - latch width field code plus one, multiplexed only
// - access takes four cycles plus programmed parameters
// - shared port carries address, then data
`timescale 1ns/10ps
module ext_mem_timing (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic       i_acc_req,
  input  wire logic       i_acc_write,
  input  wire logic       i_acc_wide,
  input  wire logic [15:0] i_acc_addr,
  input  wire logic [7:0] i_acc_ptr,
  input  wire logic [7:0] i_acc_wdata,
  output logic            o_acc_done,
  output logic      [7:0] o_acc_rdata,
  output logic      [7:0] o_addr_hi,
  output logic            o_addr_hi_oe,
  output logic      [7:0] o_ad,
  output logic            o_ad_oe,
  input  wire logic [7:0] i_ad,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  input  wire logic [7:0] i_data,
  output logic            o_ale,
  output logic            o_rd_n,
  output logic            o_wr_n
);
  import ext_mem_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] external_memory_timing_ff, external_memory_config_ff, bank_page_register_ff;

  // page select never reaches this decode, so every page sees the registers
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      external_memory_timing_ff <= TIMING_RST;
    end else if (i_sfr_wr && i_sfr_addr == TIMING_ADDR) begin
      external_memory_timing_ff <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      external_memory_config_ff <= CONFIG_RST;
    end else if (i_sfr_wr && i_sfr_addr == CONFIG_ADDR) begin
      external_memory_config_ff <= i_sfr_wdata & CONFIG_MASK;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bank_page_register_ff <= BANK_RST;
    end else if (i_sfr_wr && i_sfr_addr == BANK_ADDR) begin
      bank_page_register_ff <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      case (i_sfr_addr)
        TIMING_ADDR: o_sfr_rdata <= external_memory_timing_ff;
        CONFIG_ADDR: o_sfr_rdata <= external_memory_config_ff;
        BANK_ADDR:   o_sfr_rdata <= bank_page_register_ff;
        default:     o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // access snapshot
  // ----------------------------------------------------------------
  // settings are frozen per access so a mid-access write cannot tear a phase
  logic [7:0]  acc_tc_ff, acc_cf_ff, acc_bank_ff, acc_wdata_ff;
  logic        acc_wr_ff, acc_wide_ff;
  logic [15:0] acc_addr_ff;
  state_t      state_ff, nxt_state;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      {acc_tc_ff, acc_cf_ff, acc_bank_ff} <= {TIMING_RST, CONFIG_RST, BANK_RST};
      {acc_wr_ff, acc_wide_ff, acc_addr_ff, acc_wdata_ff} <= '0;
    end else if (state_ff == ST_IDLE && i_acc_req) begin
      acc_tc_ff    <= external_memory_timing_ff;
      acc_cf_ff    <= external_memory_config_ff;
      acc_bank_ff  <= bank_page_register_ff;
      acc_wr_ff    <= i_acc_write;
      acc_wide_ff  <= i_acc_wide;
      acc_addr_ff  <= i_acc_wide ? i_acc_addr : {8'h00, i_acc_ptr};
      acc_wdata_ff <= i_acc_wdata;
    end
  end

  // live values while idle, frozen ones once the access has begun
  logic        idle, cur_wr, cur_wide, cur_mux;
  logic [7:0]  cur_tc, cur_cf, cur_bank, cur_wdata;
  logic [15:0] cur_addr;
  logic [1:0]  f_setup, f_hold, f_latch;
  logic [3:0]  f_width;

  assign idle      = (state_ff == ST_IDLE);
  assign cur_tc    = idle ? external_memory_timing_ff : acc_tc_ff;
  assign cur_cf    = idle ? external_memory_config_ff : acc_cf_ff;
  assign cur_bank  = idle ? bank_page_register_ff : acc_bank_ff;
  assign cur_wr    = idle ? i_acc_write : acc_wr_ff;
  assign cur_wide  = idle ? i_acc_wide : acc_wide_ff;
  assign cur_addr  = idle ? (i_acc_wide ? i_acc_addr : {8'h00, i_acc_ptr}) : acc_addr_ff;
  assign cur_wdata = idle ? i_acc_wdata : acc_wdata_ff;
  assign cur_mux   = ~cur_cf[MUX_BIT];
  assign f_setup   = cur_tc[SETUP_MSB:SETUP_LSB];
  assign f_width   = cur_tc[WIDTH_MSB:WIDTH_LSB];
  assign f_hold    = cur_tc[HOLD_MSB:HOLD_LSB];
  assign f_latch   = cur_cf[LATCH_MSB:LATCH_LSB];

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  phase_timer_if tif ();

  phase_timer u_timer (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .tif       (tif.tmr)
  );

  state_t after_addr;
  assign after_addr = (f_setup == 2'h0) ? ST_STROBE : ST_SETUP;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:    if (i_acc_req) nxt_state = ST_ADDR;
      ST_ADDR:    nxt_state = cur_mux ? ST_ALE_HI : after_addr;
      ST_ALE_HI:  if (tif.zero) nxt_state = ST_ALE_LO;
      ST_ALE_LO:  if (tif.zero) nxt_state = after_addr;
      ST_SETUP:   if (tif.zero) nxt_state = ST_STROBE;
      ST_STROBE: begin
        if (tif.zero) nxt_state = (f_hold == 2'h0) ? ST_RELEASE : ST_HOLD;
      end
      ST_HOLD:    if (tif.zero) nxt_state = ST_RELEASE;
      ST_RELEASE: nxt_state = ST_DONE;
      ST_DONE:    nxt_state = ST_IDLE;
      default:    nxt_state = ST_IDLE;
    endcase
  end

  always_comb begin
    tif.load     = (nxt_state != state_ff);
    tif.load_val = '0;
    case (nxt_state)
      ST_ALE_HI: tif.load_val = TMR_W'(f_latch);
      ST_ALE_LO: tif.load_val = TMR_W'(f_latch);
      ST_SETUP:  tif.load_val = TMR_W'(f_setup - 2'h1);
      ST_STROBE: tif.load_val = f_width;
      ST_HOLD:   tif.load_val = TMR_W'(f_hold - 2'h1);
      default:   tif.load_val = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // pin drive, all from next state so the pins leave flip-flops
  // ----------------------------------------------------------------
  logic drive, data_phase, strobe, bank_mode, nxt_ad_oe;

  assign drive      = nxt_state inside {ST_ADDR, ST_ALE_HI, ST_ALE_LO,
                                        ST_SETUP, ST_STROBE, ST_HOLD};
  assign data_phase = nxt_state inside {ST_SETUP, ST_STROBE, ST_HOLD};
  assign strobe     = (nxt_state == ST_STROBE);
  assign bank_mode  = (cur_cf[REGION_MSB:REGION_LSB] == REGION_BANK);
  // the latch keeps the low address only once the latch strobe has fallen
  assign nxt_ad_oe  = cur_mux ? (drive && (!data_phase || cur_wr)) : drive;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_ale  <= 1'b0;
    end else begin
      o_rd_n <= ~(strobe && !cur_wr);
      o_wr_n <= ~(strobe && cur_wr);
      o_ale  <= (nxt_state == ST_ALE_HI);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_addr_hi    <= 8'h00;
      o_addr_hi_oe <= 1'b0;
    end else begin
      o_addr_hi_oe <= drive && (cur_wide || bank_mode);
      o_addr_hi    <= cur_wide ? cur_addr[15:8] : cur_bank;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_ad      <= 8'h00;
      o_ad_oe   <= 1'b0;
      o_data    <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_ad_oe   <= nxt_ad_oe;
      o_ad      <= (cur_mux && data_phase) ? cur_wdata : cur_addr[7:0];
      o_data_oe <= !cur_mux && cur_wr && data_phase;
      o_data    <= cur_wdata;
    end
  end

  // ----------------------------------------------------------------
  // read return
  // ----------------------------------------------------------------
  // two-stage sync costs two cycles, so a tap marks the last strobe-low cycle
  // and the sample is taken two cycles later; with zero hold the load data
  // therefore lands one cycle after done
  logic [7:0] ad_s1_ff, ad_s2_ff, data_s1_ff, data_s2_ff;
  logic [1:0] rd_tap_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      {ad_s1_ff, ad_s2_ff, data_s1_ff, data_s2_ff} <= '0;
      rd_tap_ff <= 2'h0;
    end else begin
      {ad_s2_ff, ad_s1_ff}     <= {ad_s1_ff, i_ad};
      {data_s2_ff, data_s1_ff} <= {data_s1_ff, i_data};
      rd_tap_ff <= {rd_tap_ff[0], (state_ff == ST_STROBE && tif.zero && !acc_wr_ff)};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_acc_rdata <= 8'h00;
    end else if (rd_tap_ff[1]) begin
      o_acc_rdata <= acc_cf_ff[MUX_BIT] ? data_s2_ff : ad_s2_ff;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_acc_done <= 1'b0;
    end else begin
      o_acc_done <= (nxt_state == ST_DONE);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [5:0] dwell_ff, busy_ff, low_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      {dwell_ff, busy_ff, low_ff} <= '0;
    end else begin
      dwell_ff <= (nxt_state != state_ff) ? 6'h00 : dwell_ff + 6'h01;
      busy_ff  <= idle ? 6'h00 : busy_ff + 6'h01;
      low_ff   <= (!o_rd_n || !o_wr_n) ? low_ff + 6'h01 : 6'h00;
    end
  end

  chk_setup_len: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state_ff == ST_SETUP && nxt_state != ST_SETUP) |-> int'(dwell_ff) + 1 == int'(f_setup))
    else $error("address setup length wrong");
  chk_strobe_width: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(o_rd_n & o_wr_n) |-> int'(low_ff) == int'(acc_tc_ff[WIDTH_MSB:WIDTH_LSB]) + 1)
    else $error("strobe width wrong");
  chk_hold_len: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state_ff == ST_HOLD && nxt_state != ST_HOLD) |-> int'(dwell_ff) + 1 == int'(f_hold))
    else $error("address hold length wrong");
  chk_ale_high: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state_ff == ST_ALE_HI && nxt_state != ST_ALE_HI) |-> dwell_ff == 6'(f_latch))
    else $error("latch strobe high length wrong");
  chk_ale_low: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state_ff == ST_ALE_LO && nxt_state != ST_ALE_LO) |-> dwell_ff == 6'(f_latch) && o_rd_n && o_wr_n)
    else $error("latch strobe low length wrong");
  chk_total_cycles: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_acc_done |-> int'(busy_ff) + 2 == ACCESS_OVERHEAD + int'(f_setup) + int'(f_width) + 1
      + int'(f_hold) + (cur_mux ? 2 * (int'(f_latch) + 1) : 0))
    else $error("access length wrong");
  chk_one_strobe: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !o_rd_n |-> (o_wr_n && !acc_wr_ff && o_addr_hi_oe == (acc_wide_ff || bank_mode)))
    else $error("wrong strobe for access");
  chk_no_bank: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (!idle && !acc_wide_ff && !bank_mode) |-> ##1 !o_addr_hi_oe)
    else $error("upper byte driven without bank select");
  chk_bank_drive: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (o_addr_hi_oe && !acc_wide_ff && !idle) |-> o_addr_hi == acc_bank_ff)
    else $error("upper byte not from bank register");
  chk_write_data: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(o_wr_n) && !cur_mux |-> o_data_oe == (acc_tc_ff[HOLD_MSB:HOLD_LSB] != 2'h0))
    else $error("write data hold wrong");
  chk_reset_defaults: assert property (@(posedge i_sys_clk)
    $past(i_reset) |-> external_memory_timing_ff == TIMING_RST)
    else $error("timing register not at maximum after reset");
endmodule : ext_mem_timing

// >>> verification/ext_mem_model.sv
// ext_mem_model: asynchronous byte-wide memory behind a transparent address latch
// assumes the bench resolves each port from the enables and feeds the result back
`timescale 1ns/10ps
module ext_mem_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_mux,
  input  wire logic [7:0] i_addr_hi,
  input  wire logic       i_addr_hi_oe,
  input  wire logic [7:0] i_ad,
  input  wire logic [7:0] i_data,
  input  wire logic       i_ale,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  output logic      [7:0] o_rd_val
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat;
  logic [7:0]  last_ff;
  logic [15:0] addr;
  // ----------------------------------------------------------------
  // address decode and storage
  // ----------------------------------------------------------------
  // undriven upper pins are taken as pulled low
  assign addr = {i_addr_hi_oe ? i_addr_hi : 8'h00, i_mux ? lat : i_ad};
  always_latch begin
    if (i_ale) lat <= i_ad;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_wr_n) mem[addr] <= i_mux ? i_ad : i_data;
    if (!i_rd_n) last_ff <= mem[addr];
  end
  // valid for the whole strobe, then the bus floats to the inverse so stale data never matches
  assign o_rd_val = i_rd_n ? ~last_ff : mem[addr];
endmodule : ext_mem_model

// >>> verification/tb_ext_mem_timing.sv
// tb_ext_mem_timing: self-checking bench for the external memory strobe timer
// assumes ext_mem_model stands on the pins; the bank register is written once
`timescale 1ns/10ps
module tb_ext_mem_timing;
  import ext_mem_pkg::*;
  typedef struct packed {
    logic [7:0]  t;
    logic [7:0]  c;
    logic        wide;
    logic [15:0] a;
    logic [7:0]  p;
    logic [7:0]  d;
  } row_t;
  logic        clk, rst, sw, sr, req, aw, awide, mux, inacc, bad_wd;
  logic [7:0]  sa, sd, ptr, wd, srd, ard, hi, ad, dat, rv, ad_w, dat_w, hi_s, lo_s, exp_wd;
  logic [15:0] aa;
  logic        hi_oe, ad_oe, dat_oe, ale, rd_n, wr_n, done;
  int          failures, comparisons, cyc, n_rd, n_wr, n_ale, hi_cnt;
  row_t        rows [7] = '{
    '{8'h00, 8'h14, 1'b1, 16'h1234, 8'h00, 8'hA1},
    '{8'h5A, 8'h18, 1'b0, 16'h0000, 8'h3C, 8'h5B},
    '{8'hA5, 8'h1C, 1'b0, 16'h0000, 8'hC3, 8'h6E},
    '{8'h00, 8'h04, 1'b1, 16'hBEEF, 8'h00, 8'h81},
    '{8'h47, 8'h0B, 1'b0, 16'h0000, 8'h55, 8'h2D},
    '{8'hC4, 8'h0E, 1'b0, 16'h0000, 8'hAA, 8'hF0},
    '{8'h3C, 8'h18, 1'b1, 16'h0F0F, 8'h00, 8'h3C}};
  assign ad_w  = ad_oe ? ad : (mux ? rv : ~rv);
  assign dat_w = dat_oe ? dat : (mux ? ~rv : rv);
  ext_mem_timing dut (.i_sys_clk(clk), .i_reset(rst), .i_sfr_addr(sa), .i_sfr_wr(sw),
    .i_sfr_rd(sr), .i_sfr_wdata(sd), .o_sfr_rdata(srd), .i_acc_req(req), .i_acc_write(aw),
    .i_acc_wide(awide), .i_acc_addr(aa), .i_acc_ptr(ptr), .i_acc_wdata(wd), .o_acc_done(done),
    .o_acc_rdata(ard), .o_addr_hi(hi), .o_addr_hi_oe(hi_oe), .o_ad(ad), .o_ad_oe(ad_oe),
    .i_ad(ad_w), .o_data(dat), .o_data_oe(dat_oe), .i_data(dat_w), .o_ale(ale),
    .o_rd_n(rd_n), .o_wr_n(wr_n));
  ext_mem_model mem (.i_sys_clk(clk), .i_mux(mux), .i_addr_hi(hi), .i_addr_hi_oe(hi_oe),
    .i_ad(ad_w), .i_data(dat_w), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n), .o_rd_val(rv));
  // ----------------------------------------------------------------
  // clock, pin monitor, helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // sampled on the falling edge, where registered pins have settled
  always @(negedge clk) begin
    if (inacc) begin
      if (!rd_n) n_rd++;
      if (!wr_n) n_wr++;
      if (ale) n_ale++;
      if (hi_oe) begin
        hi_cnt++;
        hi_s = hi;
      end
      if (ale || (!mux && !(rd_n && wr_n))) lo_s = ad;
      if (!wr_n && !(mux ? (ad_oe && ad === exp_wd) : (dat_oe && dat === exp_wd))) bad_wd = 1;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sw <= 1'b1;
    sa <= a;
    sd <= d;
    @(posedge clk);
    sw <= 1'b0;
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    sr <= 1'b1;
    sa <= a;
    @(posedge clk);
    sr <= 1'b0;
    #1 v = srd;
  endtask : sfr_rd
  // hold above one keeps the request up while the access is already busy
  task automatic acc(input logic w, input logic wide, input logic [15:0] a,
                     input logic [7:0] p, input logic [7:0] d, input int hold, output int n);
    n_rd = 0;
    n_wr = 0;
    n_ale = 0;
    hi_cnt = 0;
    bad_wd = 0;
    exp_wd = d;
    inacc = 1;
    @(posedge clk);
    req <= 1'b1;
    aw <= w;
    awide <= wide;
    aa <= a;
    ptr <= p;
    wd <= d;
    repeat (hold) @(posedge clk);
    req <= 1'b0;
    n = hold;
    #1;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
      #1;
    end
    inacc = 0;
  endtask : acc
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    row_t       r;
    int         n, s, w, h, l, ex;
    logic       bk, extra;
    logic [7:0] v;
    {rst, sw, sr, req, aw, awide, mux, inacc} = 8'h81;
    {sa, sd, ptr, wd, aa} = 48'h0;
    {failures, comparisons, cyc} = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    sfr_wr(BANK_ADDR, 8'h7E);
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      mux = !r.c[MUX_BIT];
      sfr_wr(TIMING_ADDR, r.t);
      sfr_wr(CONFIG_ADDR, r.c);
      s = r.t[7:6];
      w = r.t[5:2];
      h = r.t[1:0];
      l = r.c[1:0];
      ex = 4 + s + w + 1 + h + (mux ? 2 * l + 2 : 0);
      bk = (r.c[3:2] == REGION_BANK);
      for (int k = 0; k < 2; k++) begin
        acc(k == 0, r.wide, r.a, r.p, r.d, 1, n);
        check(n + 1 == ex, "access length");
        check((k ? n_rd : n_wr) == w + 1 && (k ? n_wr : n_rd) == 0, "strobe");
        check(n_ale == (mux ? l + 1 : 0), "latch width");
        check((hi_cnt > 0) == (r.wide || bk), "upper drive");
        check(!(r.wide || bk) || hi_s === (r.wide ? r.a[15:8] : 8'h7E), "upper");
        check(lo_s === (r.wide ? r.a[7:0] : r.p), "low address");
        check(k == 1 || !bad_wd, "write data");
        if (k == 1) begin
          @(posedge clk);
          #1;
          check(ard === r.d, "read data");
        end
      end
    end
    // second reset mid-run, then the defaults and the awkward cases
    mux = 1'b1;
    do_reset();
    sfr_rd(TIMING_ADDR, v);
    check(v === TIMING_RST, "timing reset");
    sfr_rd(CONFIG_ADDR, v);
    check(v === CONFIG_RST, "config reset");
    acc(1'b1, 1'b1, 16'h4321, 8'h00, 8'h99, 2, n);
    check(n + 1 == 28 && n_wr == 16, "default access");
    extra = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) extra = 1;
    end
    check(!extra, "busy request");
    sfr_rd(8'h86, v);
    check(v === 8'h00, "unmapped read");
    sfr_wr(CONFIG_ADDR, 8'hFF);
    sfr_rd(CONFIG_ADDR, v);
    check(v === CONFIG_MASK, "config mask");
    sfr_wr(TIMING_ADDR, 8'h5A);
    sfr_rd(TIMING_ADDR, v);
    check(v === 8'h5A, "timing rw");
    tally_and_finish();
  end
endmodule : tb_ext_mem_timing
